// ---- core/boot_strap_regs.svh ----
// offsets, field positions, reset values and counts of the boot strap selector
`ifndef BOOT_STRAP_REGS_SVH
`define BOOT_STRAP_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BSS_STATUS_OFS 12'h000
`define BSS_PINCTL_OFS 12'h004
`define BSS_FUSE_OFS 12'h008
// ----------------------------------------------------------------
// strap bit positions
// ----------------------------------------------------------------
`define BSS_SRC_SEL_BIT 0
`define BSS_DL_REQ_BIT 1
`define BSS_SPARE_BIT 2
`define BSS_TYPE_BIT 3
// ----------------------------------------------------------------
// status and fuse register fields
// ----------------------------------------------------------------
`define BSS_ST_STRAP_LSB 0
`define BSS_ST_SRC_LSB 4
`define BSS_ST_TYPE_BIT 6
`define BSS_ST_DONE_BIT 7
`define BSS_ST_STATE_LSB 8
`define BSS_FU_EN_BIT 0
`define BSS_FU_CFG_LSB 4
// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define BSS_PINCTL_RST 4'h0
`define BSS_STRAP_W 4
`define BSS_FUSE_CFG_W 4
`endif

// ---- core/boot_strap_pkg.sv ----
// types shared by the boot strap selector files
package boot_strap_pkg;
  // decoded boot source
  typedef enum logic [1:0] {
    SRC_EMMC = 2'b00,
    SRC_USB_DL = 2'b01,
    SRC_FUSE = 2'b10
  } boot_src_t;
  // boot sequence states
  typedef enum logic [2:0] {
    ST_CAPTURE = 3'b000,
    ST_DECIDE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN_APP = 3'b011,
    ST_RUN_RT = 3'b100
  } boot_state_t;
endpackage

// ---- core/strap_capture.sv ----
// one-shot sampler that freezes a level vector at the first edge after reset
`timescale 1ns/100ps
module strap_capture #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] level_in,
  output logic [W-1:0] level_held,
  output logic captured
);
  // ----------------------------------------------------------------
  // capture once, then hold until the next reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_held <= '0;
      captured <= 1'b0;
    end else if (!captured) begin
      // first edge after release takes the pin levels
      level_held <= level_in;
      captured <= 1'b1;
    end
  end
endmodule

// ---- core/boot_source_strap_select.sv ----
// boot strap capture, boot source decode, boot sequence and apb registers
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "boot_strap_regs.svh"
// Operation
// RQ1 - sample four straps at reset release
// RQ2 - strap pins become outputs after boot
// RQ3 - type strap low gives single boot
// RQ4 - type strap high gives low-power boot
// RQ5 - single boot loads images, then app cores
// RQ6 - select low, request high: boot eMMC
// RQ7 - both high: boot from fuse settings
// RQ8 - request low forces usb serial download
// RQ9 - fuse boot only when fuse enable set
// RQ10 - board must not drive straps at reset
// RQ11 - driven straps need fuse programming instead
// RQ12 - captured straps hold until next reset
module boot_source_strap_select
  import boot_strap_pkg::*;
#(
  parameter int STRAP_W = `BSS_STRAP_W,
  parameter int FUSE_W = `BSS_FUSE_CFG_W
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap pins, two-way
  input wire logic [STRAP_W-1:0] boot_strap_pins_in,
  output logic [STRAP_W-1:0] boot_strap_pins_out,
  output logic [STRAP_W-1:0] boot_strap_pins_oe_n,
  // fuse bank levels
  input wire logic fuse_boot_enable,
  input wire logic [FUSE_W-1:0] fuse_boot_cfg,
  // image loader handshake
  input wire logic images_loaded,
  output logic load_start,
  // boot results
  output logic [1:0] boot_source,
  output logic low_power_boot,
  output logic boot_valid,
  output logic app_core_run,
  output logic rt_core_run
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int CAP_W = STRAP_W + FUSE_W + 1;
  logic [CAP_W-1:0] cap_in; // straps and fuse levels together
  logic [CAP_W-1:0] cap_held; // frozen copy
  logic cap_done; // capture has happened
  logic [STRAP_W-1:0] strap_r; // captured strap levels
  logic fuse_en_r; // captured fuse enable
  logic [FUSE_W-1:0] fuse_cfg_r; // captured fuse configuration
  boot_state_t state_r; // boot sequence state
  boot_state_t state_nxt; // its next value
  boot_src_t src_r; // decoded source
  logic [STRAP_W-1:0] pinctl_r; // software pin levels after boot
  logic apb_setup; // setup phase seen
  logic apb_done; // access completes this edge
  logic [31:0] rd_mux; // read data selection
  logic addr_ok; // address hits a register

  // ----------------------------------------------------------------
  // decode function
  // ----------------------------------------------------------------
  // boot source from the captured straps and fuse enable
  function automatic boot_src_t decode_src(input logic [STRAP_W-1:0] s, input logic fen);
    boot_src_t r;
    r = SRC_EMMC;
    // RQ8 download request wins
    if (!s[`BSS_DL_REQ_BIT]) begin
      r = SRC_USB_DL;
    end else if (!s[`BSS_SRC_SEL_BIT]) begin
      // RQ6 grounded select picks emmc
      r = SRC_EMMC;
    end else begin
      // RQ7 RQ9 fuses only when enabled
      r = fen ? SRC_FUSE : SRC_USB_DL;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // relies on the board leaving straps undriven at reset (RQ10, RQ11)
  assign cap_in = {fuse_cfg_r_in(fuse_boot_cfg), fuse_boot_enable, boot_strap_pins_in};

  // identity helper keeps the concatenation widths explicit
  function automatic logic [FUSE_W-1:0] fuse_cfg_r_in(input logic [FUSE_W-1:0] v);
    return v;
  endfunction

  // RQ1 sample at first edge after release
  strap_capture #(
    .W(CAP_W)
  ) u_cap (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(cap_in),
    .level_held(cap_held),
    .captured(cap_done)
  );

  assign strap_r = cap_held[STRAP_W-1:0];
  assign fuse_en_r = cap_held[STRAP_W];
  assign fuse_cfg_r = cap_held[CAP_W-1:STRAP_W+1];

  // ----------------------------------------------------------------
  // boot sequence
  // ----------------------------------------------------------------
  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_CAPTURE: begin
        if (cap_done) begin
          state_nxt = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        // RQ3 RQ4 type strap picks the boot type
        if (strap_r[`BSS_TYPE_BIT]) begin
          state_nxt = ST_RUN_RT;
        end else begin
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // RQ5 wait for every image
        if (images_loaded) begin
          state_nxt = ST_RUN_APP;
        end
      end
      ST_RUN_APP: state_nxt = ST_RUN_APP;
      ST_RUN_RT: state_nxt = ST_RUN_RT;
      default: state_nxt = ST_CAPTURE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_CAPTURE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // RQ12 source decoded once and then held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= SRC_EMMC;
      boot_valid <= 1'b0;
      low_power_boot <= 1'b0;
    end else if (state_r == ST_DECIDE) begin
      src_r <= decode_src(strap_r, fuse_en_r);
      boot_valid <= 1'b1;
      low_power_boot <= strap_r[`BSS_TYPE_BIT];
    end
  end

  assign boot_source = src_r;

  // core run and loader outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_start <= 1'b0;
      app_core_run <= 1'b0;
      rt_core_run <= 1'b0;
    end else begin
      // RQ5 loader active until images are in
      load_start <= (state_nxt == ST_LOAD);
      app_core_run <= (state_nxt == ST_RUN_APP);
      // RQ4 only the real-time core runs
      rt_core_run <= (state_nxt == ST_RUN_RT);
    end
  end

  // ----------------------------------------------------------------
  // strap pin drive
  // ----------------------------------------------------------------
  // RQ2 undriven until boot_valid is set, outputs from the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_strap_pins_oe_n <= '1;
      boot_strap_pins_out <= '0;
    end else begin
      boot_strap_pins_oe_n <= boot_valid ? '0 : '1;
      boot_strap_pins_out <= pinctl_r;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && pready;
  assign addr_ok = (paddr == `BSS_STATUS_OFS) || (paddr == `BSS_PINCTL_OFS) ||
                   (paddr == `BSS_FUSE_OFS);

  // read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `BSS_STATUS_OFS: begin
        rd_mux[`BSS_ST_STRAP_LSB +: STRAP_W] = strap_r;
        rd_mux[`BSS_ST_SRC_LSB +: 2] = src_r;
        rd_mux[`BSS_ST_TYPE_BIT] = low_power_boot;
        rd_mux[`BSS_ST_DONE_BIT] = boot_valid;
        rd_mux[`BSS_ST_STATE_LSB +: 3] = state_r;
      end
      `BSS_PINCTL_OFS: rd_mux[STRAP_W-1:0] = pinctl_r;
      `BSS_FUSE_OFS: begin
        rd_mux[`BSS_FU_EN_BIT] = fuse_en_r;
        rd_mux[`BSS_FU_CFG_LSB +: FUSE_W] = fuse_cfg_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: ready rises at the end of the first access cycle, high in the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !addr_ok || (pwrite && (paddr != `BSS_PINCTL_OFS));
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // pin control register, written at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pinctl_r <= `BSS_PINCTL_RST;
    end else if (apb_done && pwrite && (paddr == `BSS_PINCTL_OFS)) begin
      pinctl_r <= pwdata[STRAP_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [STRAP_W-1:0] strap_first; // straps seen at the first edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_first <= '0;
    end else if (!cap_done) begin
      strap_first <= boot_strap_pins_in;
    end
  end

  sequence s_decide;
    state_r == ST_DECIDE;
  endsequence
  sequence s_single;
    s_decide ##0 !strap_r[`BSS_TYPE_BIT];
  endsequence

  a_strap_sample: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    cap_done |-> strap_r == strap_first)
    else $error("captured straps differ from first sample");
  a_pins_drive: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    $rose(boot_valid) |=> boot_strap_pins_oe_n == '0)
    else $error("strap pins not driven after boot");
  a_single_boot: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    s_single |=> (load_start && !rt_core_run))
    else $error("single boot not started");
  a_low_power: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    s_decide ##0 strap_r[`BSS_TYPE_BIT] |=> ##1 (rt_core_run && !app_core_run))
    else $error("low-power boot not started");
  a_app_release: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    $rose(app_core_run) |-> $past(images_loaded) && $past(state_r == ST_LOAD))
    else $error("app cores released before images loaded");
  a_emmc_pick: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    s_decide ##0 (strap_r[1:0] == 2'b10) |=> boot_source == SRC_EMMC)
    else $error("emmc not chosen");
  a_fuse_pick: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    s_decide ##0 (strap_r[1:0] == 2'b11) && fuse_en_r |=> boot_source == SRC_FUSE)
    else $error("fuse source not chosen");
  a_download_pick: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    s_decide ##0 !strap_r[`BSS_DL_REQ_BIT] |=> boot_source == SRC_USB_DL)
    else $error("download request ignored");
  a_fuse_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    s_decide ##0 (strap_r[1:0] == 2'b11) && !fuse_en_r |=> boot_source == SRC_USB_DL)
    else $error("fuse boot without enable");
  a_hold_stable: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    boot_valid |=> $stable(boot_source) && $stable(strap_r) && boot_valid)
    else $error("boot decision changed after capture");
endmodule

// ---- testbench/strap_jumper_board.sv ----
// carrier board jumpers and strap pull resistors seen by the strap pins
`timescale 1ns/100ps
module strap_jumper_board (
  input wire logic src_gnd, // source select jumper inserted
  input wire logic dl_gnd, // download jumper inserted
  input wire logic lp_gnd, // boot type input pulled high, low-power boot
  input wire logic [3:0] pins_out, // device pin drive
  input wire logic [3:0] pins_oe_n, // device enables, low drives
  output logic [3:0] pins_level // resolved wire levels
);
  logic [3:0] board_lvl; // levels set by jumpers and pulls
  // ----------------------------------------------------------------
  // jumper levels
  // ----------------------------------------------------------------
  // select and request jumpers
  assign board_lvl[0] = ~src_gnd;
  assign board_lvl[1] = ~dl_gnd;
  // spare strap held by its pull-down
  assign board_lvl[2] = 1'b0;
  assign board_lvl[3] = lp_gnd;
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // only pulls on the board, device wins once driving
  assign pins_level = (pins_oe_n & board_lvl) | (~pins_oe_n & pins_out);
endmodule

// ---- testbench/boot_source_strap_select_tb.sv ----
// self-checking bench for the boot strap selector
`timescale 1ns/100ps
module boot_source_strap_select_tb
  import boot_strap_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, fuse_boot_enable, images_loaded;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_s, q;
  logic pready, pslverr, rdy_s, err_s, e;
  logic [3:0] pins_in, pins_out, pins_oe_n, fuse_boot_cfg;
  logic [1:0] boot_source;
  logic low_power_boot, boot_valid, app_core_run, rt_core_run, load_start;
  logic src_gnd, dl_gnd, lp_gnd;
  int n_errors, checked;
  // ----------------------------------------------------------------
  // clock, design and board
  // ----------------------------------------------------------------
  always #10 pclk = ~pclk;
  boot_source_strap_select uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_strap_pins_in(pins_in),
    .boot_strap_pins_out(pins_out), .boot_strap_pins_oe_n(pins_oe_n),
    .fuse_boot_enable(fuse_boot_enable), .fuse_boot_cfg(fuse_boot_cfg),
    .images_loaded(images_loaded), .load_start(load_start), .boot_source(boot_source),
    .low_power_boot(low_power_boot), .boot_valid(boot_valid),
    .app_core_run(app_core_run), .rt_core_run(rt_core_run));
  strap_jumper_board board (.src_gnd(src_gnd), .dl_gnd(dl_gnd), .lp_gnd(lp_gnd),
    .pins_out(pins_out), .pins_oe_n(pins_oe_n), .pins_level(pins_in));
  // apb answer as it stood at the coming rising edge
  always @(negedge pclk) begin
    rdy_s <= pready;
    rd_s <= prdata;
    err_s <= pslverr;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rdy_s !== 1'b1 && n < 20);
    chk(rdy_s, 1'b1);
    q = rd_s;
    e = err_s;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task final_report;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // reset with given jumpers, then check the whole boot
  task boot_case(input logic s, input logic d, input logic l, input logic f,
                 input logic [1:0] xs);
    int n;
    @(posedge pclk);
    presetn <= 1'b0;
    src_gnd <= s;
    dl_gnd <= d;
    lp_gnd <= l;
    fuse_boot_enable <= f;
    fuse_boot_cfg <= {f, 3'h5};
    images_loaded <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (boot_valid !== 1'b1 && n < 10) begin
      @(negedge pclk);
      n++;
    end
    chk(boot_valid, 1'b1);
    chk(boot_source, xs);
    chk(low_power_boot, l);
    chk(rt_core_run, l);
    chk(load_start, !l);
    if (!l) begin
      chk(app_core_run, 1'b0);
      @(posedge pclk);
      images_loaded <= 1'b1;
      n = 0;
      while (app_core_run !== 1'b1 && n < 10) begin
        @(negedge pclk);
        n++;
      end
      chk(load_start, 1'b0);
    end
    chk(app_core_run, !l);
    repeat (2) @(negedge pclk);
    chk(pins_oe_n, 4'h0);
    apb(1'b0, `BSS_STATUS_OFS, 32'h0);
    chk(q[10:0], {l ? ST_RUN_RT : ST_RUN_APP, 1'b1, l, xs, l, 1'b0, ~d, ~s});
    apb(1'b0, `BSS_FUSE_OFS, 32'h0);
    chk({q[7:4], q[0]}, {f, 3'h5, f});
    // later pin and fuse activity must not move the result
    @(posedge pclk);
    fuse_boot_enable <= ~f;
    src_gnd <= ~s;
    dl_gnd <= ~d;
    repeat (3) @(negedge pclk);
    chk(boot_source, xs);
    chk(boot_valid, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
    pwdata = 32'h0; fuse_boot_enable = 0; fuse_boot_cfg = 4'h0; images_loaded = 0;
    src_gnd = 1; dl_gnd = 0; lp_gnd = 0; n_errors = 0; checked = 0;
    boot_case(1'b1, 1'b0, 1'b0, 1'b0, SRC_EMMC);
    boot_case(1'b0, 1'b0, 1'b0, 1'b1, SRC_FUSE);
    boot_case(1'b0, 1'b0, 1'b0, 1'b0, SRC_USB_DL);
    boot_case(1'b1, 1'b1, 1'b0, 1'b1, SRC_USB_DL);
    boot_case(1'b0, 1'b1, 1'b1, 1'b1, SRC_USB_DL);
    apb(1'b0, `BSS_PINCTL_OFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `BSS_PINCTL_OFS, 32'hFFFF_FFFA);
    chk(e, 1'b0);
    apb(1'b0, `BSS_PINCTL_OFS, 32'h0);
    chk(q, 32'h0000_000A);
    chk(pins_out, 4'hA);
    apb(1'b1, `BSS_STATUS_OFS, 32'h0000_0000);
    chk(e, 1'b1);
    chk(boot_source, SRC_USB_DL);
    apb(1'b0, 12'h00C, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    final_report;
  end
  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    final_report;
  end
endmodule
